// [design/smc_sleep_ctrl.sv]
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "smc_map.svh"
module smc_sleep_ctrl #(
  parameter logic [14:0] XTAL_START_CYC = 15'(`SMC_XTAL_START)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_instr,
  input wire logic [3:0] clock_source_fuses,
  input wire logic brownout_fuse_on,
  input wire logic wdt_enable,
  input wire logic comp_uses_ref,
  input wire logic ext_irq_line_a,
  input wire logic ext_irq_line_b,
  input wire logic ext_irq_line_c,
  input wire logic [1:0] ext_level_mode,
  input wire logic int_irq,
  input wire logic ext_reset_req,
  input wire logic wdt_reset_req,
  input wire logic bod_reset_req,
  output logic core_clock_en,
  output logic flash_clock_en,
  output logic io_clock_en,
  output logic osc_en,
  output logic comp_en,
  output logic vref_en,
  output logic bod_en,
  output logic wdt_run,
  output logic in_buf_en,
  output logic wake_buf_en,
  output logic core_halt,
  output logic irq_resume,
  output logic reset_vector_req
);
  typedef struct packed {
    smc_pkg::smc_state_t state;
    smc_pkg::smc_mode_t mode;
    logic [7:0] core_control;
    logic [7:0] core_control_status;
    logic [7:0] extended_control;
    logic [7:0] comparator_ctrl_status;
    logic [2:0] irq_s1;
    logic [2:0] irq_s2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic core_clock_en;
    logic flash_clock_en;
    logic io_clock_en;
    logic osc_en;
    logic comp_en;
    logic vref_en;
    logic bod_en;
    logic wdt_run;
    logic in_buf_en;
    logic wake_buf_en;
    logic core_halt;
    logic irq_resume;
    logic reset_vector_req;
  } smc_ctrl_t;

  smc_ctrl_t s_r;
  smc_ctrl_t s_nxt;
  smc_timer_if tmr_if ();

  logic [2:0] sel_code;
  logic crystal_src;
  logic code_ok;
  logic sleep_go;
  logic wake_idle;
  logic wake_deep;
  logic reset_wake;
  logic comp_off;
  logic setup_ph;
  logic [31:0] rd_word;
  logic rd_hit;
  logic deep_sleep;

  smc_wake_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tmr(tmr_if.timer)
  );

  always_comb begin
    sel_code = {s_r.core_control_status[`SMC_BIT_SEL2],
                s_r.core_control[`SMC_BIT_SEL1],
                s_r.extended_control[`SMC_BIT_SEL0]};
    crystal_src = (clock_source_fuses >= `SMC_XTAL_MIN);
    code_ok = (sel_code == `SMC_CODE_IDLE) || (sel_code == `SMC_CODE_PDOWN) ||
              ((sel_code == `SMC_CODE_STBY) && crystal_src);
    sleep_go = sleep_instr && s_r.core_control[`SMC_BIT_ARM] && code_ok;
    // Synced pins only; the raw first stage is never looked at
    wake_idle = (|s_r.irq_s2) || int_irq;
    wake_deep = (s_r.irq_s2[0] && ext_level_mode[0]) ||
                (s_r.irq_s2[1] && ext_level_mode[1]) || s_r.irq_s2[2];
    reset_wake = ext_reset_req || wdt_reset_req || bod_reset_req;
    comp_off = s_r.comparator_ctrl_status[`SMC_BIT_COMP_OFF];
    setup_ph = psel && !penable;
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    if (paddr == `SMC_OFF_CORE_CTRL) begin
      rd_word[7:0] = s_r.core_control;
    end else if (paddr == `SMC_OFF_CORE_STAT) begin
      rd_word[7:0] = s_r.core_control_status;
    end else if (paddr == `SMC_OFF_EXT_CTRL) begin
      rd_word[7:0] = s_r.extended_control;
    end else if (paddr == `SMC_OFF_COMP_CTRL) begin
      rd_word[7:0] = s_r.comparator_ctrl_status;
    end else if (paddr == `SMC_OFF_SLEEP_STAT) begin
      rd_word[7:0] = {3'h0, code_ok, s_r.mode, s_r.state};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    s_nxt = s_r;
    tmr_if.load = 1'b0;
    tmr_if.count = `SMC_HALT_CYC;
    s_nxt.irq_s1 = {ext_irq_line_c, ext_irq_line_b, ext_irq_line_a};
    s_nxt.irq_s2 = s_r.irq_s1;
    s_nxt.irq_resume = 1'b0;
    s_nxt.reset_vector_req = 1'b0;

    // Registers answer in the setup cycle so the access phase never waits
    s_nxt.pready = setup_ph;
    s_nxt.pslverr = setup_ph && !rd_hit;
    if (setup_ph && !pwrite) begin
      s_nxt.prdata = rd_word;
    end
    if (psel && penable && pwrite && s_r.pready) begin
      if (paddr == `SMC_OFF_CORE_CTRL) begin
        s_nxt.core_control = pwdata[7:0];
      end else if (paddr == `SMC_OFF_CORE_STAT) begin
        s_nxt.core_control_status = pwdata[7:0];
      end else if (paddr == `SMC_OFF_EXT_CTRL) begin
        s_nxt.extended_control = pwdata[7:0];
      end else if (paddr == `SMC_OFF_COMP_CTRL) begin
        s_nxt.comparator_ctrl_status = pwdata[7:0];
      end
    end

    case (s_r.state)
      smc_pkg::ST_RUN: begin
        if (sleep_go) begin
          s_nxt.state = smc_pkg::ST_SLEEP;
          if (sel_code == `SMC_CODE_IDLE) begin
            s_nxt.mode = smc_pkg::MD_IDLE;
          end else if (sel_code == `SMC_CODE_PDOWN) begin
            s_nxt.mode = smc_pkg::MD_PDOWN;
          end else begin
            s_nxt.mode = smc_pkg::MD_STBY;
          end
        end
      end
      smc_pkg::ST_SLEEP: begin
        if (reset_wake) begin
          s_nxt.state = smc_pkg::ST_RUN;
          s_nxt.reset_vector_req = 1'b1;
        end else if (s_r.mode == smc_pkg::MD_IDLE) begin
          if (wake_idle) begin
            s_nxt.state = smc_pkg::ST_HALT;
            tmr_if.load = 1'b1;
          end
        end else if (wake_deep) begin
          s_nxt.state = smc_pkg::ST_START;
          tmr_if.load = 1'b1;
          if (s_r.mode == smc_pkg::MD_STBY) begin
            tmr_if.count = `SMC_STBY_START;
          end else if (crystal_src) begin
            tmr_if.count = XTAL_START_CYC;
          end else begin
            tmr_if.count = `SMC_PD_START_RC;
          end
        end
      end
      smc_pkg::ST_START: begin
        if (reset_wake) begin
          s_nxt.state = smc_pkg::ST_RUN;
          s_nxt.reset_vector_req = 1'b1;
        end else if (tmr_if.done) begin
          s_nxt.state = smc_pkg::ST_HALT;
          tmr_if.load = 1'b1;
        end
      end
      smc_pkg::ST_HALT: begin
        if (reset_wake) begin
          s_nxt.state = smc_pkg::ST_RUN;
          s_nxt.reset_vector_req = 1'b1;
        end else if (tmr_if.done) begin
          s_nxt.state = smc_pkg::ST_RUN;
          s_nxt.irq_resume = 1'b1;
        end
      end
      default: begin
        s_nxt.state = smc_pkg::ST_RUN;
      end
    endcase

    // Outputs follow the next state so every pin comes from a flop
    deep_sleep = (s_nxt.state == smc_pkg::ST_SLEEP) && (s_nxt.mode != smc_pkg::MD_IDLE);
    s_nxt.core_clock_en = (s_nxt.state == smc_pkg::ST_RUN);
    s_nxt.core_halt = (s_nxt.state != smc_pkg::ST_RUN);
    s_nxt.flash_clock_en = (s_nxt.state == smc_pkg::ST_RUN) ||
                           (s_nxt.state == smc_pkg::ST_HALT);
    s_nxt.io_clock_en = (s_nxt.state == smc_pkg::ST_RUN) ||
                        (s_nxt.state == smc_pkg::ST_HALT) ||
                        ((s_nxt.state == smc_pkg::ST_SLEEP) &&
                         (s_nxt.mode == smc_pkg::MD_IDLE));
    // Power-down oscillator is off; restarting it is what the start-up wait covers
    s_nxt.osc_en = !((s_nxt.state == smc_pkg::ST_SLEEP) &&
                     (s_nxt.mode == smc_pkg::MD_PDOWN));
    s_nxt.comp_en = !comp_off && !deep_sleep;
    s_nxt.vref_en = brownout_fuse_on || (comp_uses_ref && !comp_off);
    s_nxt.bod_en = brownout_fuse_on;
    s_nxt.wdt_run = wdt_enable;
    s_nxt.in_buf_en = s_nxt.io_clock_en;
    s_nxt.wake_buf_en = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.state <= smc_pkg::ST_RUN;
      s_r.mode <= smc_pkg::MD_IDLE;
      s_r.core_control <= `SMC_RST_REG;
      s_r.core_control_status <= `SMC_RST_REG;
      s_r.extended_control <= `SMC_RST_REG;
      s_r.comparator_ctrl_status <= `SMC_RST_REG;
      s_r.core_clock_en <= 1'b1;
      s_r.flash_clock_en <= 1'b1;
      s_r.io_clock_en <= 1'b1;
      s_r.osc_en <= 1'b1;
      s_r.comp_en <= 1'b1;
      s_r.in_buf_en <= 1'b1;
      s_r.wake_buf_en <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign core_clock_en = s_r.core_clock_en;
  assign flash_clock_en = s_r.flash_clock_en;
  assign io_clock_en = s_r.io_clock_en;
  assign osc_en = s_r.osc_en;
  assign comp_en = s_r.comp_en;
  assign vref_en = s_r.vref_en;
  assign bod_en = s_r.bod_en;
  assign wdt_run = s_r.wdt_run;
  assign in_buf_en = s_r.in_buf_en;
  assign wake_buf_en = s_r.wake_buf_en;
  assign core_halt = s_r.core_halt;
  assign irq_resume = s_r.irq_resume;
  assign reset_vector_req = s_r.reset_vector_req;

  // Helper: cycles spent in the halt phase
  logic [2:0] halt_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_cnt <= 3'h0;
    end else if (s_r.state == smc_pkg::ST_HALT) begin
      halt_cnt <= halt_cnt + 3'h1;
    end else begin
      halt_cnt <= 3'h0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sel_bit_pos: assert property (
    (s_r.state == smc_pkg::ST_RUN) && sleep_go && !s_r.extended_control[7] &&
    !s_r.core_control[4] && !s_r.core_control_status[5]
    |=> s_r.mode == smc_pkg::MD_IDLE)
    else $error("select bit 0 not taken from bit 7");
  a_bad_code_noop: assert property (
    (s_r.state == smc_pkg::ST_RUN) && sleep_instr && !code_ok
    |=> s_r.state == smc_pkg::ST_RUN)
    else $error("reserved code entered sleep");
  a_stby_crystal: assert property (
    $rose(s_r.state == smc_pkg::ST_SLEEP) && (s_r.mode == smc_pkg::MD_STBY)
    |-> crystal_src)
    else $error("standby without crystal source");
  a_arm_needed: assert property (
    (s_r.state == smc_pkg::ST_RUN) && !s_r.core_control[`SMC_BIT_ARM]
    |=> s_r.state == smc_pkg::ST_RUN)
    else $error("sleep entered without arm bit");
  a_idle_clocks: assert property (
    (s_r.state == smc_pkg::ST_SLEEP) && (s_r.mode == smc_pkg::MD_IDLE)
    |-> !core_clock_en && !flash_clock_en && io_clock_en && osc_en)
    else $error("idle clock set wrong");
  a_pdown_clocks: assert property (
    (s_r.state == smc_pkg::ST_SLEEP) && (s_r.mode == smc_pkg::MD_PDOWN)
    |-> !io_clock_en && !osc_en && !in_buf_en && !comp_en)
    else $error("power-down left a clock running");
  a_stby_wake6: assert property (
    (s_r.state == smc_pkg::ST_SLEEP) && (s_r.mode == smc_pkg::MD_STBY) &&
    wake_deep && !reset_wake
    |=> (s_r.state == smc_pkg::ST_START)[*6] ##1 s_r.state == smc_pkg::ST_HALT)
    else $error("standby start-up not six cycles");
  a_halt_four: assert property (
    (s_r.state == smc_pkg::ST_HALT) && !reset_wake |-> halt_cnt < 3'h4)
    else $error("halt phase longer than four cycles");
  a_pdown_no_int: assert property (
    (s_r.state == smc_pkg::ST_SLEEP) && (s_r.mode == smc_pkg::MD_PDOWN) &&
    !wake_deep && !reset_wake |=> s_r.state == smc_pkg::ST_SLEEP)
    else $error("power-down woke on wrong source");
  a_reset_wake: assert property (
    (s_r.state != smc_pkg::ST_RUN) && reset_wake
    |=> reset_vector_req && (s_r.state == smc_pkg::ST_RUN))
    else $error("reset during sleep did not wake");
  a_vref_need: assert property (
    ##1 (vref_en == ($past(brownout_fuse_on) || ($past(comp_uses_ref) &&
    !$past(comp_off)))))
    else $error("reference enable wrong");
  a_keep_bod_wdt: assert property (
    ##1 (bod_en == $past(brownout_fuse_on)) && (wdt_run == $past(wdt_enable)))
    else $error("detector or watchdog dropped in sleep");

  c_idle_cycle: cover property (
    (s_r.state == smc_pkg::ST_SLEEP) && (s_r.mode == smc_pkg::MD_IDLE)
    ##[1:50] irq_resume);
  c_pdown_wake: cover property (
    (s_r.state == smc_pkg::ST_START) && (s_r.mode == smc_pkg::MD_PDOWN)
    ##[1:100] irq_resume);
  c_stby_wake: cover property (
    (s_r.state == smc_pkg::ST_START) && (s_r.mode == smc_pkg::MD_STBY)
    ##[1:20] irq_resume);
  c_reset_wake: cover property (reset_vector_req);
endmodule : smc_sleep_ctrl
`default_nettype wire

// [design/smc_map.svh]
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH
`define SMC_OFF_CORE_CTRL 12'h000
`define SMC_OFF_CORE_STAT 12'h004
`define SMC_OFF_EXT_CTRL 12'h008
`define SMC_OFF_COMP_CTRL 12'h00c
`define SMC_OFF_SLEEP_STAT 12'h010
`define SMC_BIT_ARM 5
`define SMC_BIT_SEL1 4
`define SMC_BIT_SEL2 5
`define SMC_BIT_SEL0 7
`define SMC_BIT_COMP_OFF 7
`define SMC_RST_REG 8'h00
`define SMC_CODE_IDLE 3'h0
`define SMC_CODE_PDOWN 3'h2
`define SMC_CODE_STBY 3'h6
`define SMC_XTAL_MIN 4'ha
`define SMC_PD_START_RC 15'h0006
`define SMC_STBY_START 15'h0006
`define SMC_HALT_CYC 15'h0004
`define SMC_XTAL_START 16384
`endif

// [design/smc_pkg.sv]
package smc_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_START = 2'b10,
    ST_HALT = 2'b11
  } smc_state_t;

  typedef enum logic [1:0] {
    MD_IDLE = 2'b00,
    MD_PDOWN = 2'b01,
    MD_STBY = 2'b10
  } smc_mode_t;

  typedef struct packed {
    logic [14:0] cnt;
    logic done;
  } smc_tmr_t;
endpackage : smc_pkg

// [design/smc_timer_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface smc_timer_if;
  logic load;
  logic [14:0] count;
  logic done;
  modport ctrl (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface : smc_timer_if
`default_nettype wire

// [design/smc_wake_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module smc_wake_timer (
  input wire logic pclk,
  input wire logic presetn,
  smc_timer_if.timer tmr
);
  smc_pkg::smc_tmr_t s_r;
  smc_pkg::smc_tmr_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (tmr.load) begin
      s_nxt.cnt = tmr.count;
    end else if (s_r.cnt != 15'h0000) begin
      s_nxt.cnt = s_r.cnt - 15'h0001;
    end
    // Flag the last counted cycle so the waiter leaves after exactly N cycles
    s_nxt.done = (s_nxt.cnt == 15'h0001);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tmr.done = s_r.done;

  a_done_once: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.done |=> !s_r.done)
    else $error("wake timer done held longer than one cycle");
endmodule : smc_wake_timer
`default_nettype wire

// [bench/smc_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module smc_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic irq_resume,
  input wire logic reset_vector_req,
  output logic sleep_instr,
  output int resumes,
  output int restarts
);
  // One-cycle sleep instruction; the bench writes the arm bit first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_instr <= 1'b0;
      resumes <= 0;
      restarts <= 0;
    end else begin
      sleep_instr <= req;
      if (irq_resume === 1'b1) resumes <= resumes + 1;
      if (reset_vector_req === 1'b1) restarts <= restarts + 1;
    end
  end
endmodule : smc_core_model
`default_nettype wire

// [bench/sleep_mode_controller_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "smc_map.svh"
module sleep_mode_controller_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req, sleep_instr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] clock_source_fuses;
  logic brownout_fuse_on, wdt_enable, comp_uses_ref, int_irq;
  logic ext_irq_line_a, ext_irq_line_b, ext_irq_line_c;
  logic [1:0] ext_level_mode;
  logic ext_reset_req, wdt_reset_req, bod_reset_req;
  logic core_clock_en, flash_clock_en, io_clock_en, osc_en, comp_en, vref_en;
  logic bod_en, wdt_run, in_buf_en, wake_buf_en, core_halt, irq_resume, reset_vector_req;
  logic [8:0] outs_seen;
  logic [7:0] mdl [5];
  int num_errors, total_checks, exp_res, exp_rst, resumes, restarts, m;
  assign outs_seen = {core_clock_en, flash_clock_en, io_clock_en, osc_en, comp_en,
    vref_en, bod_en, wdt_run, in_buf_en};
  smc_sleep_ctrl #(.XTAL_START_CYC(15'h0014)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_instr,
    .clock_source_fuses, .brownout_fuse_on, .wdt_enable, .comp_uses_ref,
    .ext_irq_line_a, .ext_irq_line_b, .ext_irq_line_c, .ext_level_mode, .int_irq,
    .ext_reset_req, .wdt_reset_req, .bod_reset_req, .core_clock_en, .flash_clock_en,
    .io_clock_en, .osc_en, .comp_en, .vref_en, .bod_en, .wdt_run, .in_buf_en,
    .wake_buf_en, .core_halt, .irq_resume, .reset_vector_req);
  smc_core_model core (.pclk, .presetn, .req, .irq_resume, .reset_vector_req,
    .sleep_instr, .resumes, .restarts);
  always #10 pclk = ~pclk;
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    if (a < 12'h010) mdl[a[4:2]] = d[7:0];
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp, "read data");
    chk(32'(e), 32'(err), "slave error");
  endtask : rdchk
  task automatic set_sel(input logic [2:0] c, input logic arm);
    wr(`SMC_OFF_EXT_CTRL, {24'h0, c[0], 7'h0});
    wr(`SMC_OFF_CORE_CTRL, {26'h0, arm, c[1], 4'h0});
    wr(`SMC_OFF_CORE_STAT, {26'h0, c[2], 5'h0});
  endtask : set_sel
  function automatic int mode_of(input int c, input logic xtal);
    if (c == 0) return 0;
    if (c == 2) return 1;
    if (c == 6 && xtal) return 2;
    return 3;
  endfunction : mode_of
  // Mode 3 means running; order matches outs_seen
  function automatic logic [8:0] exp_outs(input int m);
    logic on, cmp, ref_on;
    on = (m == 3);
    cmp = (m == 0 || on) && !mdl[3][7];
    ref_on = brownout_fuse_on | (comp_uses_ref & !mdl[3][7]);
    return {on, on, on || m == 0, m != 1, cmp, ref_on, brownout_fuse_on, wdt_enable,
      on || m == 0};
  endfunction : exp_outs
  task automatic sleep_try(input int m);
    req <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(core_halt), 32'(m < 3), "halt");
    chk(32'(wake_buf_en), 32'h1, "wake buffers");
    chk(32'(outs_seen), 32'(exp_outs(m)), "domains");
  endtask : sleep_try
  // Wake line stays at its level until resume, so slow sync cannot miss it
  task automatic wake_wait(input int lo, input int hi);
    int n;
    n = 0;
    while (irq_resume !== 1'b1 && n < hi) begin
      @(posedge pclk);
      n++;
    end
    if (n >= hi) begin
      num_errors++;
      tally_and_finish();
    end
    chk(32'(n >= lo), 32'h1, "wake too early");
    exp_res++;
    repeat (2) @(posedge pclk);
    chk(32'(outs_seen), 32'(exp_outs(3)), "resumed");
  endtask : wake_wait
  task automatic rst_wake(input int src);
    {ext_reset_req, wdt_reset_req, bod_reset_req} <= 3'(1 << src);
    @(posedge pclk);
    {ext_reset_req, wdt_reset_req, bod_reset_req} <= 3'h0;
    exp_rst++;
    repeat (3) @(posedge pclk);
    chk(32'(core_halt), 32'h0, "reset wake");
  endtask : rst_wake
  initial begin
    pclk = 1'b0;
    presetn <= 1'b0;
    {psel, penable, pwrite, req, int_irq, brownout_fuse_on, wdt_enable} <= 7'h00;
    {comp_uses_ref, ext_irq_line_a, ext_irq_line_b, ext_irq_line_c} <= 4'h0;
    {ext_reset_req, wdt_reset_req, bod_reset_req} <= 3'h0;
    {paddr, pwdata, ext_level_mode} <= 46'h0;
    clock_source_fuses <= 4'h1;
    for (int i = 0; i < 5; i++) mdl[i] = `SMC_RST_REG;
    void'($urandom(3475));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(outs_seen), 32'(exp_outs(3)), "after reset");
    for (int i = 0; i < 4; i++) rdchk(12'(i * 4), 32'h0, 1'b0);
    rdchk(12'h020, 32'h0, 1'b1);
    rdchk(`SMC_OFF_SLEEP_STAT, 32'h10, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(12'(i * 8), $urandom);
      rdchk(12'(i * 8), {24'h0, mdl[i * 2]}, 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      {brownout_fuse_on, wdt_enable, comp_uses_ref} <= 3'($urandom);
      set_sel(3'(i), 1'b1);
      m = mode_of(i, 1'b0);
      sleep_try(m);
      if (m < 3) rst_wake(i % 3);
    end
    set_sel(3'h0, 1'b0);
    sleep_try(3);
    clock_source_fuses <= `SMC_XTAL_MIN;
    set_sel(3'h6, 1'b1);
    sleep_try(2);
    ext_irq_line_c <= 1'b1;
    wake_wait(10, 30);
    ext_irq_line_c <= 1'b0;
    set_sel(3'h2, 1'b1);
    sleep_try(1);
    int_irq <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(32'(core_halt), 32'h1, "internal wake in deep sleep");
    int_irq <= 1'b0;
    ext_level_mode <= 2'b10;
    ext_irq_line_b <= 1'b1;
    wake_wait(24, 45);
    ext_irq_line_b <= 1'b0;
    clock_source_fuses <= 4'h1;
    ext_level_mode <= 2'b01;
    set_sel(3'h2, 1'b1);
    sleep_try(1);
    ext_irq_line_a <= 1'b1;
    wake_wait(10, 30);
    ext_irq_line_a <= 1'b0;
    wr(`SMC_OFF_COMP_CTRL, 32'h80);
    set_sel(3'h0, 1'b1);
    sleep_try(0);
    int_irq <= 1'b1;
    wake_wait(4, 20);
    int_irq <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(32'(resumes), 32'(exp_res), "resume count");
    chk(32'(restarts), 32'(exp_rst), "restart count");
    tally_and_finish();
  end
endmodule : sleep_mode_controller_tb_top
`default_nettype wire
